// >>> src/exec_pkg.sv
// Purpose: shared constants for the instruction subset execution unit
// Assumes: 8-bit data, 13-bit program counter, 8-deep stack by default
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus
package exec_pkg;
    // operation codes written by software into the command register
    localparam logic [4:0] OP_NONE        = 5'h00;
    localparam logic [4:0] OP_CALL        = 5'h01;
    localparam logic [4:0] OP_MEM_ZERO    = 5'h02;
    localparam logic [4:0] OP_BIT_CLEAR   = 5'h03;
    localparam logic [4:0] OP_KICK        = 5'h04;
    localparam logic [4:0] OP_PREKICK_1   = 5'h05;
    localparam logic [4:0] OP_PREKICK_2   = 5'h06;
    localparam logic [4:0] OP_INV_MEM     = 5'h07;
    localparam logic [4:0] OP_INV_WORK    = 5'h08;
    localparam logic [4:0] OP_BCD_ADJUST  = 5'h09;
    localparam logic [4:0] OP_DEC_MEM     = 5'h0A;
    localparam logic [4:0] OP_DEC_WORK    = 5'h0B;
    localparam logic [4:0] OP_INC_MEM     = 5'h0C;
    localparam logic [4:0] OP_INC_WORK    = 5'h0D;
    localparam logic [4:0] OP_POWER_DOWN  = 5'h0E;
    // register byte offsets
    localparam logic [7:0] OFF_CMD        = 8'h00;
    localparam logic [7:0] OFF_WORK       = 8'h04;
    localparam logic [7:0] OFF_FLAGS      = 8'h08;
    localparam logic [7:0] OFF_PC         = 8'h0C;
    localparam logic [7:0] OFF_MEM_ADDR   = 8'h10;
    localparam logic [7:0] OFF_MEM_DATA   = 8'h14;
    localparam logic [7:0] OFF_WDT        = 8'h18;
    localparam logic [7:0] OFF_STACK      = 8'h1C;
    // command word fields: op [4:0], bit index [10:8], mem addr [23:16]
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 8;
    localparam int CMD_ADDR_LSB = 16;
    // flag register bit positions
    localparam int FLAG_C   = 0;
    localparam int FLAG_AC  = 1;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_PDF = 3;
    localparam int FLAG_TO  = 4;
    localparam int FLAG_BSY = 5;
    // fixed constants
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] BYTE_ONE     = 8'h01;
    localparam logic [3:0] NIBBLE_NINE  = 4'h9;
    localparam logic [7:0] ADJ_LOW      = 8'h06;
    localparam logic [7:0] ADJ_HIGH     = 8'h60;
    localparam logic [1:0] AXI_OKAY     = 2'h0;
    localparam logic [1:0] AXI_SLVERR   = 2'h2;
    localparam int         CALL_CYCLES  = 2;
endpackage

// >>> src/bcd_adjust_unit.sv
// Purpose: decimal adjust of the working register after a BCD addition
// Assumes: carry and aux carry flags reflect the preceding addition
// Notes:   purely combinational; result goes to data memory
`timescale 1ns/1ps
module bcd_adjust_unit (
    input  wire logic [7:0] value,       // working register contents
    input  wire logic       carry_in,    // carry flag
    input  wire logic       aux_carry,   // aux carry flag
    output logic      [7:0] adjusted,    // value plus 00/06/60/66
    output logic            carry_out    // new carry flag
);
    logic       fix_low;                 // low nibble needs plus 6
    logic       fix_high;                // high nibble needs plus 6
    logic [7:0] addend;                  // chosen correction
    logic [8:0] sum;                     // nine bits to catch carry
    // low nibble over nine or aux carry set
    assign fix_low  = (value[3:0] > exec_pkg::NIBBLE_NINE)
                      || aux_carry;      // [RULE8]
    // high nibble over nine or carry set; a low fix may push it there too
    assign fix_high = (value[7:4] > exec_pkg::NIBBLE_NINE) || carry_in
                      || (fix_low && value[7:4] == exec_pkg::NIBBLE_NINE
                          && value[3:0] > exec_pkg::NIBBLE_NINE); // [RULE9]
    assign addend = (fix_low  ? exec_pkg::ADJ_LOW  : exec_pkg::BYTE_ZERO)
                  | (fix_high ? exec_pkg::ADJ_HIGH : exec_pkg::BYTE_ZERO);
    assign sum       = {1'b0, value} + {1'b0, addend};   // [RULE10]
    assign adjusted  = sum[7:0];
    // carry only ever set, never cleared, so multi-byte sums chain
    assign carry_out = carry_in || sum[8] || fix_high;   // [RULE10]
endmodule // bcd_adjust_unit

// >>> src/instr_exec.sv
// Purpose: executes a subset of 8-bit core instructions issued over AXI
// Assumes: one command at a time; software polls the busy flag
// Notes:   data memory and call stack live inside this block
`timescale 1ns/1ps
// Function
// RULE1: call pushes pc plus one, jumps, two cycles
// RULE2: memory zero writes 00, flags untouched
// RULE3: bit clear zeroes one bit only, no flags
// RULE4: kick clears watchdog, timeout and power-down flags
// RULE5: prekicks act only when alternated
// RULE6: invert memory writes one's complement back
// RULE7: invert to working, memory kept, zero flag
// RULE8: low nibble plus six if over nine or aux
// RULE9: high nibble plus six if over nine or carry
// RULE10: adjust writes memory, only carry changes
// RULE11: decrement memory in place, zero flag
// RULE12: decrement to working, memory kept, zero flag
// RULE13: increment memory in place, zero flag
// RULE14: increment to working, memory kept, zero flag
// RULE15: power down halts execution, keeps state
// RULE16: power down clears watchdog, sets pdf, clears timeout
// RULE17: pair clears flags only when consecutive
// RULE18: increment and decrement wrap modulo 256
module instr_exec #(
    parameter int MEM_DEPTH   = 256,     // data memory bytes
    parameter int STACK_DEPTH = 8,       // call stack levels
    parameter int PC_WIDTH    = 13       // program counter width
) (
    input  wire logic        aclk,       // 200 MHz clock
    input  wire logic        aresetn,    // synchronous reset, low
    input  wire logic [7:0]  awaddr,     // write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        wdt_timeout,  // pulse from watchdog counter
    output logic             halted_reg,   // system clock gate request
    output logic             wdt_clear_reg // one-cycle watchdog clear
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,                // waiting for command
        ST_EXEC = 3'b010,                // one instruction cycle
        ST_CALL = 3'b100                 // second cycle of a call
    } state_t;

    localparam int SP_W = $clog2(STACK_DEPTH);

    logic [7:0]          mem [MEM_DEPTH];    // data memory
    logic [PC_WIDTH-1:0] stack [STACK_DEPTH];// call stack
    state_t              state_reg;
    logic [31:0]         cmd_reg;            // latched command
    logic [7:0]          work_reg;           // working register
    logic                c_reg, ac_reg, z_reg, pdf_reg, to_reg;
    logic [PC_WIDTH-1:0] pc_reg;
    logic [SP_W-1:0]     sp_reg;
    logic                last_pre1_reg;      // previous op was prekick 1 not ending a pair
    logic                last_pre2_reg;      // previous op was prekick 2 not ending a pair
    logic [7:0]          mem_addr_reg;       // software memory pointer
    logic                aw_hold, w_hold;    // captured halves of write
    logic [7:0]          aw_addr_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;

    // command decode
    wire [4:0] op      = cmd_reg[exec_pkg::CMD_OP_LSB +: 5];
    wire [2:0] bit_sel = cmd_reg[exec_pkg::CMD_BIT_LSB +: 3];
    wire [7:0] m_addr  = cmd_reg[exec_pkg::CMD_ADDR_LSB +: 8];
    wire [7:0] m_val   = mem[m_addr];
    wire [7:0] inc_val = m_val + exec_pkg::BYTE_ONE;   // [RULE18]
    wire [7:0] dec_val = m_val - exec_pkg::BYTE_ONE;   // [RULE18]
    wire [7:0] inv_val = ~m_val;
    wire [7:0] bit_mask = ~(exec_pkg::BYTE_ONE << bit_sel);
    wire [7:0] bcd_val;
    wire       bcd_c;
    wire       in_exec = (state_reg == ST_EXEC);
    // pair completes only when the other half ran immediately before
    wire pair_done = in_exec
        && ((op == exec_pkg::OP_PREKICK_1 && last_pre2_reg)
         || (op == exec_pkg::OP_PREKICK_2 && last_pre1_reg)); // [RULE5]
    wire kick_now  = in_exec && (op == exec_pkg::OP_KICK);     // [RULE4]
    wire halt_now  = in_exec && (op == exec_pkg::OP_POWER_DOWN);

    bcd_adjust_unit u_bcd (
        .value     (work_reg),
        .carry_in  (c_reg),
        .aux_carry (ac_reg),
        .adjusted  (bcd_val),
        .carry_out (bcd_c)
    );

    // write channel capture: address and data accepted in either order
    wire wr_fire   = aw_hold && w_hold && !bvalid;
    wire cmd_write = wr_fire && aw_addr_reg == exec_pkg::OFF_CMD
                     && state_reg == ST_IDLE && !halted_reg;
    wire wr_known  = aw_addr_reg == exec_pkg::OFF_CMD
                  || aw_addr_reg == exec_pkg::OFF_WORK
                  || aw_addr_reg == exec_pkg::OFF_FLAGS
                  || aw_addr_reg == exec_pkg::OFF_MEM_ADDR
                  || aw_addr_reg == exec_pkg::OFF_MEM_DATA;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= exec_pkg::AXI_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold     <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold     <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_known ? exec_pkg::AXI_OKAY
                                    : exec_pkg::AXI_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = !aw_hold && !bvalid;
    assign wready  = !w_hold && !bvalid;

    // read channel: one cycle to answer
    wire [31:0] rd_mux =
        araddr == exec_pkg::OFF_CMD   ? cmd_reg :
        araddr == exec_pkg::OFF_WORK  ? {24'h0, work_reg} :
        araddr == exec_pkg::OFF_FLAGS ? {26'h0, state_reg != ST_IDLE,
                                         to_reg, pdf_reg, z_reg,
                                         ac_reg, c_reg} :
        araddr == exec_pkg::OFF_PC    ? 32'(pc_reg) :
        araddr == exec_pkg::OFF_MEM_ADDR ? {24'h0, mem_addr_reg} :
        araddr == exec_pkg::OFF_MEM_DATA ? {24'h0, mem[mem_addr_reg]} :
        araddr == exec_pkg::OFF_STACK ? 32'(sp_reg) : 32'h0000_0000;
    wire rd_known = araddr <= exec_pkg::OFF_STACK && araddr[1:0] == 2'h0
                    && araddr != exec_pkg::OFF_WDT;
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= exec_pkg::AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= rd_known ? exec_pkg::AXI_OKAY : exec_pkg::AXI_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // sequencer: idle, one execute cycle, extra cycle for calls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            cmd_reg   <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_write && w_strb_reg[0]) begin
                        cmd_reg   <= w_data_reg;
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg <= (op == exec_pkg::OP_CALL) ? ST_CALL
                                                          : ST_IDLE; // [RULE1]
                end
                ST_CALL: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // data memory write port: execution first, software otherwise
    always_ff @(posedge aclk) begin
        if (in_exec) begin
            case (op)
                exec_pkg::OP_MEM_ZERO:  mem[m_addr] <= exec_pkg::BYTE_ZERO; // [RULE2]
                exec_pkg::OP_BIT_CLEAR: mem[m_addr] <= m_val & bit_mask;  // [RULE3]
                exec_pkg::OP_INV_MEM:   mem[m_addr] <= inv_val;           // [RULE6]
                exec_pkg::OP_BCD_ADJUST: mem[m_addr] <= bcd_val;          // [RULE10]
                exec_pkg::OP_DEC_MEM:   mem[m_addr] <= dec_val;           // [RULE11]
                exec_pkg::OP_INC_MEM:   mem[m_addr] <= inc_val;           // [RULE13]
                default: ;
            endcase
        end else if (wr_fire && aw_addr_reg == exec_pkg::OFF_MEM_DATA
                     && w_strb_reg[0]) begin
            mem[mem_addr_reg] <= w_data_reg[7:0];
        end
    end

    // working register and arithmetic flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work_reg <= exec_pkg::BYTE_ZERO;
            c_reg    <= 1'b0;
            ac_reg   <= 1'b0;
            z_reg    <= 1'b0;
            mem_addr_reg <= 8'h00;
        end else if (in_exec) begin
            case (op)
                exec_pkg::OP_INV_MEM: z_reg <= (inv_val == 8'h00);
                exec_pkg::OP_INV_WORK: begin
                    work_reg <= inv_val;                  // [RULE7]
                    z_reg    <= (inv_val == 8'h00);       // [RULE7]
                end
                exec_pkg::OP_BCD_ADJUST: c_reg <= bcd_c;  // [RULE10]
                exec_pkg::OP_DEC_MEM: z_reg <= (dec_val == 8'h00); // [RULE11]
                exec_pkg::OP_DEC_WORK: begin
                    work_reg <= dec_val;                  // [RULE12]
                    z_reg    <= (dec_val == 8'h00);       // [RULE12]
                end
                exec_pkg::OP_INC_MEM: z_reg <= (inc_val == 8'h00); // [RULE13]
                exec_pkg::OP_INC_WORK: begin
                    work_reg <= inc_val;                  // [RULE14]
                    z_reg    <= (inc_val == 8'h00);       // [RULE14]
                end
                default: ;
            endcase
        end else if (wr_fire && w_strb_reg[0]) begin
            // software preloads operands and flags between commands
            if (aw_addr_reg == exec_pkg::OFF_WORK)
                work_reg <= w_data_reg[7:0];
            if (aw_addr_reg == exec_pkg::OFF_FLAGS) begin
                c_reg  <= w_data_reg[exec_pkg::FLAG_C];
                ac_reg <= w_data_reg[exec_pkg::FLAG_AC];
                z_reg  <= w_data_reg[exec_pkg::FLAG_Z];
            end
            if (aw_addr_reg == exec_pkg::OFF_MEM_ADDR)
                mem_addr_reg <= w_data_reg[7:0];
        end
    end

    // watchdog flags, pair tracking and halt; timeout set wins on a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_reg        <= 1'b0;
            pdf_reg       <= 1'b0;
            last_pre1_reg <= 1'b0;
            last_pre2_reg <= 1'b0;
            halted_reg    <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else begin
            wdt_clear_reg <= kick_now || pair_done || halt_now; // [RULE16]
            if (in_exec) begin
                last_pre1_reg <= (op == exec_pkg::OP_PREKICK_1) && !pair_done;
                last_pre2_reg <= (op == exec_pkg::OP_PREKICK_2) && !pair_done;
            end
            if (kick_now || pair_done) begin
                pdf_reg <= 1'b0;                  // [RULE4] [RULE17]
            end else if (halt_now) begin
                pdf_reg <= 1'b1;                  // [RULE16]
            end
            if (wdt_timeout) begin
                to_reg <= 1'b1;                   // set beats clear
            end else if (kick_now || pair_done || halt_now) begin
                to_reg <= 1'b0;                   // [RULE4] [RULE16]
            end
            // a halted core stays put until reset; data is retained
            if (halt_now) begin
                halted_reg <= 1'b1;               // [RULE15]
            end
        end
    end

    // program counter and stack push for call
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg <= '0;
            sp_reg <= '0;
        end else if (in_exec) begin
            if (op == exec_pkg::OP_CALL) begin
                stack[sp_reg] <= pc_reg + PC_WIDTH'(1);             // [RULE1]
                sp_reg        <= sp_reg + SP_W'(1);
                pc_reg        <= cmd_reg[exec_pkg::CMD_ADDR_LSB
                                         +: PC_WIDTH];              // [RULE1]
            end else begin
                pc_reg <= pc_reg + PC_WIDTH'(1);
            end
        end
    end

    // checks
    call_two_cycles_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_CALL |=> state_reg == ST_CALL
        ##1 state_reg == ST_IDLE) else $error("call not two cycles"); // [RULE1]
    call_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_CALL |=> stack[$past(sp_reg)]
        == $past(pc_reg) + PC_WIDTH'(1)) else $error("call push"); // [RULE1]
    zero_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_MEM_ZERO |=> $stable(z_reg)
        && $stable(c_reg)) else $error("memory zero changed flags"); // [RULE2]
    kick_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        kick_now && !wdt_timeout |=> !to_reg && !pdf_reg && wdt_clear_reg)
        else $error("kick failed"); // [RULE4]
    prekick_repeat_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && !pair_done && op == exec_pkg::OP_PREKICK_1
        |=> $stable(pdf_reg) && !wdt_clear_reg)
        else $error("lone prekick acted"); // [RULE5]
    inv_work_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_INV_WORK
        |=> work_reg == ~$past(m_val)) else $error("invert wrong"); // [RULE7]
    inc_work_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_INC_WORK
        |=> z_reg == ($past(m_val) == 8'hFF)) else $error("inc z"); // [RULE14]
    dec_work_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_exec && op == exec_pkg::OP_DEC_WORK
        |=> work_reg == $past(m_val) - 8'h01) else $error("dec"); // [RULE12]
    halt_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halt_now |=> pdf_reg && halted_reg && wdt_clear_reg)
        else $error("halt flags"); // [RULE16]
    halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halted_reg |=> halted_reg && state_reg == ST_IDLE)
        else $error("halt released"); // [RULE15]
    call_cov: cover property (@(posedge aclk) state_reg == ST_CALL);
    pair_cov: cover property (@(posedge aclk) pair_done);
    halt_cov: cover property (@(posedge aclk) halt_now);
endmodule // instr_exec

// >>> verif/instr_exec_tb_top.sv
// Purpose: self-checking bench for the instruction execution unit
// Assumes: register map, flag bits and opcodes as held in exec_pkg
// Notes:   bench is the only bus master; halt is left only by reset
`timescale 1ns/1ps
module instr_exec_tb_top;
    logic        aclk = 0, aresetn = 0;  // clock, low-active reset
    logic [7:0]  awaddr = 0, araddr = 0; // bus addresses
    logic [31:0] wdata = 0, rdata, v;    // v holds the last word read
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, wdt_timeout = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        halted_reg, wdt_clear_reg;
    logic [1:0]  bresp, rresp, resp;     // resp: last response code
    int          num_errors = 0, checks_done = 0, kicks = 0, i, k0, s0;
    `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
        num_errors++; $display("BAD t=%0t %h %h", $time, a, b); end end
    // step tables: op, start byte, result, zero flag, result to working
    logic [4:0]  t_op [5] = '{exec_pkg::OP_INC_MEM, exec_pkg::OP_DEC_MEM,
        exec_pkg::OP_INC_WORK, exec_pkg::OP_DEC_WORK, exec_pkg::OP_INV_WORK};
    logic [7:0]  t_in [5] = '{8'hFF, 8'h00, 8'h41, 8'h01, 8'hFF};
    logic [7:0]  t_out [5] = '{8'h00, 8'hFF, 8'h42, 8'h00, 8'h00};
    logic        t_z [5] = '{1, 0, 0, 1, 1};
    logic        t_w [5] = '{0, 0, 1, 1, 1};
    // adjust: working, result, aux carry, carry, carry out, spare
    logic [19:0] b_t [6] = '{20'h0A100, 20'h23298, 20'hA2022,
        20'h45A56, 20'h99990, 20'hAB112};
    instr_exec instr_exec_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wdt_timeout(wdt_timeout), .halted_reg(halted_reg),
        .wdt_clear_reg(wdt_clear_reg));
    always #2.5 aclk = ~aclk;
    // counts watchdog clear pulses, one per effective clear
    always @(posedge aclk) if (wdt_clear_reg === 1'b1) kicks++;
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task automatic hang(input logic ok);
        if (!ok) begin
            num_errors++;
            wrap_up();
        end
    endtask
    // handshakes are judged at the negedge, where ready has settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        hb = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int n = 0; n < 50 && !hb; n++) begin
            @(negedge aclk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end
        bready <= 0;
        hang(hb);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        hr = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (int n = 0; n < 50 && !hr; n++) begin
            @(negedge aclk);
            ha = arvalid & arready;
            hr = rvalid;
            v = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
        end
        rready <= 0;
        hang(hr);
    endtask
    // issue a command, then poll until busy drops; v ends as flags
    task automatic cmd(input logic [4:0] op, input logic [2:0] b,
                       input logic [7:0] a);
        wr(exec_pkg::OFF_CMD, {8'h00, a, 5'h00, b, 3'h0, op});
        v = 32'h20;
        for (int n = 0; n < 20 && v[5] !== 1'b0; n++)
            rd(exec_pkg::OFF_FLAGS);
        hang(v[exec_pkg::FLAG_BSY] === 1'b0);
    endtask
    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        wr(exec_pkg::OFF_MEM_ADDR, {24'h0, a});
        wr(exec_pkg::OFF_MEM_DATA, {24'h0, d});
    endtask
    task automatic peek(input logic [7:0] a);
        wr(exec_pkg::OFF_MEM_ADDR, {24'h0, a});
        rd(exec_pkg::OFF_MEM_DATA);
    endtask
    task automatic tmo;
        @(posedge aclk) wdt_timeout <= 1;
        @(posedge aclk) wdt_timeout <= 0;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        wr(8'h40, 0);
        `CHK(resp, exec_pkg::AXI_SLVERR)
        rd(exec_pkg::OFF_WDT);
        `CHK(resp, exec_pkg::AXI_SLVERR)
        wr(exec_pkg::OFF_FLAGS, 32'h5);  // zero and carry set
        `CHK(resp, exec_pkg::AXI_OKAY)
        poke(8'h20, 8'hA5);
        cmd(exec_pkg::OP_MEM_ZERO, 3'h0, 8'h20);
        `CHK(v[2:0], 3'h5)
        peek(8'h20);
        `CHK(v[7:0], 8'h00)
        poke(8'h21, 8'hFF);
        cmd(exec_pkg::OP_BIT_CLEAR, 3'h7, 8'h21);
        `CHK(v[2:0], 3'h5)
        peek(8'h21);
        `CHK(v[7:0], 8'h7F)
        poke(8'h22, 8'h5A);
        cmd(exec_pkg::OP_INV_MEM, 3'h0, 8'h22);
        peek(8'h22);
        `CHK(v[7:0], 8'hA5)
        for (i = 0; i < 5; i++) begin
            poke(8'h30, t_in[i]);
            cmd(t_op[i], 3'h0, 8'h30);
            `CHK(v[2], t_z[i])
            peek(8'h30);
            `CHK(v[7:0], t_w[i] ? t_in[i] : t_out[i])
            rd(exec_pkg::OFF_WORK);
            if (t_w[i]) `CHK(v[7:0], t_out[i])
        end
        for (i = 0; i < 6; i++) begin
            wr(exec_pkg::OFF_WORK, {24'h0, b_t[i][19:12]});
            wr(exec_pkg::OFF_FLAGS, {29'h0, 1'b1, b_t[i][3:2]});
            cmd(exec_pkg::OP_BCD_ADJUST, 3'h0, 8'h31);
            `CHK(v[2:0], {2'b11 & {1'b1, b_t[i][3]}, b_t[i][1]})
            peek(8'h31);
            `CHK(v[7:0], b_t[i][11:4])
        end
        tmo;
        k0 = kicks;
        cmd(exec_pkg::OP_KICK, 3'h0, 8'h00);
        `CHK(v[4:3], 2'b00)
        tmo;
        cmd(exec_pkg::OP_PREKICK_1, 3'h0, 8'h00);
        cmd(exec_pkg::OP_PREKICK_1, 3'h0, 8'h00);
        `CHK(v[4], 1'b1)
        cmd(exec_pkg::OP_PREKICK_2, 3'h0, 8'h00);
        `CHK(v[4], 1'b0)
        tmo;
        cmd(exec_pkg::OP_PREKICK_2, 3'h0, 8'h00);
        `CHK(v[4], 1'b1)
        `CHK(kicks, k0 + 2)
        rd(exec_pkg::OFF_STACK);
        s0 = int'(v[3:0]);
        `CHK(resp, exec_pkg::AXI_OKAY)
        cmd(exec_pkg::OP_CALL, 3'h0, 8'h55);
        rd(exec_pkg::OFF_PC);
        `CHK(v[12:0], 13'h0055)
        rd(exec_pkg::OFF_STACK);
        `CHK(v[3:0], 4'(s0 + 1))
        poke(8'h40, 8'h3C);
        wr(exec_pkg::OFF_CMD, {27'h0, exec_pkg::OP_POWER_DOWN});
        for (i = 0; i < 20 && halted_reg !== 1'b1; i++) @(posedge aclk);
        `CHK(halted_reg, 1'b1)
        rd(exec_pkg::OFF_FLAGS);
        `CHK(v[4:3], 2'b01)
        `CHK(kicks, k0 + 3)
        wr(exec_pkg::OFF_CMD, {8'h00, 8'h40, 11'h0, exec_pkg::OP_INC_MEM});
        peek(8'h40);
        `CHK(v[7:0], 8'h3C)
        wrap_up();
    end
endmodule // instr_exec_tb_top
